// *** rtl/dsl_pkg.sv ***
// Constants shared by the dual converter serial word loader
package dsl_pkg;

	// Word geometry
	localparam int WORD_W = 16;
	localparam int DATA_W = 12;
	localparam int CNT_W = 5;
	localparam logic [CNT_W-1:0] WORD_BITS = 5'h10;
	localparam logic [CNT_W-1:0] LAST_BIT = 5'h0F;

	// Field positions within the word
	localparam int TARGET_HI_POS = 15;
	localparam int SPEED_POS = 14;
	localparam int PDOWN_POS = 13;
	localparam int TARGET_LO_POS = 12;
	localparam int DATA_MSB = 11;

	// Target select codes {high, low}
	localparam logic [1:0] SEL_B_AND_BUF = 2'h0;
	localparam logic [1:0] SEL_BUF_ONLY = 2'h1;
	localparam logic [1:0] SEL_A_AND_COPY = 2'h2;
	localparam logic [1:0] SEL_RESERVED = 2'h3;

	// Reset values of all latches
	localparam logic [DATA_W-1:0] CODE_RST = 12'h000;
	localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
	localparam logic SPEED_RST = 1'h0;
	localparam logic PDOWN_RST = 1'h0;

	// Sequencer states
	typedef enum logic [2:0] {
		DSL_IDLE,
		DSL_SHIFT,
		DSL_WAIT_RISE,
		DSL_COMMIT,
		DSL_DONE
	} dsl_state_t;

endpackage : dsl_pkg

// *** rtl/dsl_sync.sv ***
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module dsl_sync #(
	parameter int WIDTH = 3,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	// Asynchronous level in, synchronised level out
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] stable;

	// First stage feeds only the second stage
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			meta <= RST_VAL;
			stable <= RST_VAL;
		end else begin
			meta <= async_i;
			stable <= meta;
		end
	end

	assign sync_o = stable;

endmodule : dsl_sync

// *** rtl/dsl_shift.sv ***
// Serial input shift register with bit counter
`timescale 1ns/1ps
module dsl_shift
	import dsl_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	// Control
	input wire logic clear_i,
	input wire logic shift_i,
	input wire logic bit_i,
	// Collected word and bit count
	output logic [WORD_W-1:0] word_o,
	output logic [CNT_W-1:0] count_o
);

	logic [WORD_W-1:0] word;
	logic [CNT_W-1:0] count;
	logic [WORD_W-1:0] next_word;
	logic [CNT_W-1:0] next_count;

	// MSB first: new bit enters at the bottom
	always_comb begin
		next_word = word;
		next_count = count;
		if (clear_i) begin
			next_count = '0;
		end else if (shift_i && count != WORD_BITS) begin
			next_word = {word[WORD_W-2:0], bit_i};
			next_count = count + 5'h01;
		end
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			word <= WORD_RST;
			count <= '0;
		end else begin
			word <= next_word;
			count <= next_count;
		end
	end

	assign word_o = word;
	assign count_o = count;

endmodule : dsl_shift

// *** rtl/dsl_loader.sv ***
// Serial word loader and latches of a dual 12-bit converter
`timescale 1ns/1ps

// Summary of operation
// - Chip select fall starts a word; bits shift in MSB first on clock falls.
// - After 16 bits or chip select rise, the word goes to its latches.
// - Word is four program bits on top, twelve data bits below.
// - Bit 14 one selects fast settling, zero selects slow settling.
// - Bit 13 one powers down and ignores every other bit of the word.
// - Reset clears all latches; slow mode and normal operation result.
// - Select 00 writes B and buffer, 01 buffer, 10 A plus copy, 11 reserved.
// - Select 10 after buffer preload updates both outputs together.
// - Latches load on the first clock rise after the sixteenth fall.
// - Data bits are held as an unsigned converter code.
module dsl_loader
	import dsl_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	// Serial link pins
	input wire logic cs_n_i,
	input wire logic sclk_i,
	input wire logic din_i,
	// Converter latches
	output logic [DATA_W-1:0] dac_a_code_o,
	output logic [DATA_W-1:0] dac_b_code_o,
	output logic [DATA_W-1:0] buffer_code_o,
	// Control latch
	output logic settle_speed_select_o,
	output logic power_down_bit_o,
	// Status
	output logic update_o,
	output logic busy_o
);

	// Synchronised pins: {cs_n, sclk, din}
	logic [2:0] pins_sync;
	logic cs_n_s;
	logic sclk_s;
	logic din_s;
	logic cs_n_d;
	logic sclk_d;
	logic next_cs_n_d;
	logic next_sclk_d;
	logic cs_fall;
	logic cs_rise;
	logic sclk_fall;
	logic sclk_rise;

	// Sequencer and latches
	dsl_state_t state;
	dsl_state_t next_state;
	logic [DATA_W-1:0] dac_a_code;
	logic [DATA_W-1:0] dac_b_code;
	logic [DATA_W-1:0] buffer_code;
	logic settle_speed_select;
	logic power_down_bit;
	logic update;
	logic busy;
	logic [DATA_W-1:0] next_dac_a_code;
	logic [DATA_W-1:0] next_dac_b_code;
	logic [DATA_W-1:0] next_buffer_code;
	logic next_settle_speed_select;
	logic next_power_down_bit;
	logic next_update;
	logic next_busy;

	// Shift register interface
	logic shift_clear;
	logic shift_en;
	logic [WORD_W-1:0] word;
	logic [CNT_W-1:0] count;
	logic commit;

	// Decoded fields of the collected word
	logic [1:0] target_select;
	logic [DATA_W-1:0] word_code;
	logic taken;

	// Pin synchronisers; chip select and clock idle high
	dsl_sync #(
		.WIDTH(3),
		.RST_VAL(3'h6)
	) u_sync (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.async_i({cs_n_i, sclk_i, din_i}),
		.sync_o(pins_sync)
	);

	assign cs_n_s = pins_sync[2];
	assign sclk_s = pins_sync[1];
	assign din_s = pins_sync[0];

	// Previous levels for edge detection
	always_comb begin
		next_cs_n_d = cs_n_s;
		next_sclk_d = sclk_s;
	end

	// Edge history; reset levels match the idle pins
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cs_n_d <= 1'h1;
			sclk_d <= 1'h1;
		end else begin
			cs_n_d <= next_cs_n_d;
			sclk_d <= next_sclk_d;
		end
	end

	// Edge pulses on the reference clock
	assign cs_fall = cs_n_d & ~cs_n_s;
	assign cs_rise = ~cs_n_d & cs_n_s;
	assign sclk_fall = sclk_d & ~sclk_s;
	assign sclk_rise = ~sclk_d & sclk_s;

	// Register select field {high, low} of a word
	function automatic logic [1:0] target_of(input logic [WORD_W-1:0] w);
		return {w[TARGET_HI_POS], w[TARGET_LO_POS]};
	endfunction : target_of

	// Power-down or any non-reserved select is acted on
	function automatic logic word_taken(input logic [WORD_W-1:0] w);
		return w[PDOWN_POS] || (target_of(w) != SEL_RESERVED);
	endfunction : word_taken

	// program bits on top, data below
	assign target_select = target_of(word);
	assign word_code = word[DATA_MSB:0];
	assign taken = word_taken(word);

	// shift only within a live frame
	assign shift_en = (state == DSL_SHIFT) && !cs_n_s && sclk_fall;
	assign shift_clear = cs_fall;

	// Shift register and bit counter
	dsl_shift u_shift (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.clear_i(shift_clear),
		.shift_i(shift_en),
		.bit_i(din_s),
		.word_o(word),
		.count_o(count)
	);

	// Commit lasts one reference cycle
	assign commit = (state == DSL_COMMIT);

	// Sequencer states that count as a live frame
	function automatic logic in_frame(input dsl_state_t s);
		return (s == DSL_SHIFT) || (s == DSL_WAIT_RISE) ||
			(s == DSL_COMMIT);
	endfunction : in_frame

	// Sequencer next state
	always_comb begin
		next_state = state;
		case (state)
			DSL_IDLE: begin
				if (cs_fall) begin
					next_state = DSL_SHIFT;
				end
			end
			DSL_SHIFT: begin
				// early end on chip select rise
				if (cs_rise) begin
					next_state = (count != '0) ? DSL_COMMIT : DSL_IDLE;
				end else if (shift_en && count == LAST_BIT) begin
					next_state = DSL_WAIT_RISE;
				end
			end
			DSL_WAIT_RISE: begin
				// load on rise after sixteenth fall
				if (sclk_rise || cs_rise) begin
					next_state = DSL_COMMIT;
				end
			end
			DSL_COMMIT: begin
				next_state = cs_n_s ? DSL_IDLE : DSL_DONE;
			end
			DSL_DONE: begin
				// Extra clocks ignored until chip select rises
				if (cs_n_s) begin
					next_state = DSL_IDLE;
				end
			end
			default: begin
				next_state = DSL_IDLE;
			end
		endcase
	end

	// Sequencer state register
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state <= DSL_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Status: update pulse on an acted-on commit, frame flag
	always_comb begin
		next_update = commit && taken;
		next_busy = in_frame(next_state);
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			update <= 1'h0;
			busy <= 1'h0;
		end else begin
			update <= next_update;
			busy <= next_busy;
		end
	end

	// Control latch from the committed word
	always_comb begin
		next_settle_speed_select = settle_speed_select;
		next_power_down_bit = power_down_bit;
		if (commit && taken) begin
			if (word[PDOWN_POS]) begin
				next_power_down_bit = 1'h1;
			end else begin
				next_settle_speed_select = word[SPEED_POS];
				next_power_down_bit = 1'h0;
			end
		end
	end

	// slow mode and normal operation after reset
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			settle_speed_select <= SPEED_RST;
			power_down_bit <= PDOWN_RST;
		end else begin
			settle_speed_select <= next_settle_speed_select;
			power_down_bit <= next_power_down_bit;
		end
	end

	// Code latches; a power-down word leaves them alone
	always_comb begin
		next_dac_a_code = dac_a_code;
		next_dac_b_code = dac_b_code;
		next_buffer_code = buffer_code;
		if (commit && taken && !word[PDOWN_POS]) begin
			case (target_select)
				SEL_B_AND_BUF: begin
					next_dac_b_code = word_code;
					next_buffer_code = word_code;
				end
				SEL_BUF_ONLY: begin
					next_buffer_code = word_code;
				end
				SEL_A_AND_COPY: begin
					next_dac_a_code = word_code;
					next_dac_b_code = buffer_code;
				end
				default: begin
					next_dac_a_code = dac_a_code;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			dac_a_code <= CODE_RST;
			dac_b_code <= CODE_RST;
			buffer_code <= CODE_RST;
		end else begin
			dac_a_code <= next_dac_a_code;
			dac_b_code <= next_dac_b_code;
			buffer_code <= next_buffer_code;
		end
	end

	// Outputs straight from flops
	assign dac_a_code_o = dac_a_code;
	assign dac_b_code_o = dac_b_code;
	assign buffer_code_o = buffer_code;
	assign settle_speed_select_o = settle_speed_select;
	assign power_down_bit_o = power_down_bit;
	assign update_o = update;
	assign busy_o = busy;

endmodule : dsl_loader

// *** verification/dsl_host_model.sv ***
// Behavioural serial host driving the loader link
`timescale 1ns/1ps
module dsl_host_model (
	// Link pins
	output logic cs_n_o,
	output logic sclk_o,
	output logic din_o
);
	// Idle link, clock parked high
	initial begin
		cs_n_o = 1'b1;
		sclk_o = 1'b1;
		din_o = 1'b0;
	end
	// Send n leading bits MSB first; cs selects or leaves idle
	task automatic send(input logic [15:0] w, input int n,
		input bit split, input bit cs);
		// select falls before the first clock
		cs_n_o = cs;
		#80;
		for (int i = 0; i < n; i++) begin
			din_o = w[15-i];
			// 160 ns period, well under the limit
			#80 sclk_o = 1'b0;
			#80 sclk_o = 1'b1;
			// byte hosts pause with select held
			if (split && i == 7)
				#400;
		end
		#80 cs_n_o = 1'b1;
		din_o = ~din_o;
		#240;
	endtask : send
endmodule : dsl_host_model

// *** verification/dsl_loader_chk.sv ***
// Port checker for the serial word loader
`timescale 1ns/1ps
module dsl_loader_chk
	import dsl_pkg::*;
(
	// Clock, reset and link
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic cs_n_i,
	input wire logic sclk_i,
	input wire logic din_i,
	// Watched outputs
	input wire logic [DATA_W-1:0] dac_a_code_o,
	input wire logic [DATA_W-1:0] dac_b_code_o,
	input wire logic [DATA_W-1:0] buffer_code_o,
	input wire logic settle_speed_select_o,
	input wire logic power_down_bit_o,
	input wire logic update_o,
	input wire logic busy_o
);
	logic [37:0] all_q;
	// All latched state in one vector
	assign all_q = {dac_a_code_o, dac_b_code_o, buffer_code_o,
		settle_speed_select_o, power_down_bit_o};
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);
	upd_pulse_a: assert property (
		update_o |=> !update_o) else $error("update pulse too long");
	upd_busy_a: assert property (
		update_o |-> $past(busy_o)) else $error("update outside frame");
	hold_state_a: assert property (
		!update_o |-> $stable(all_q)) else $error("latch moved silently");
	cs_idle_a: assert property (
		cs_n_i [*8] |-> !busy_o) else $error("busy while deselected");
	frame_open_a: assert property (
		$fell(cs_n_i) |-> ##[1:5] busy_o) else $error("frame not opened");
	pdown_only_a: assert property (
		$rose(power_down_bit_o) |-> $stable(all_q[37:1]))
		else $error("power down changed other bits");
	copy_buf_a: assert property (
		update_o && $changed(dac_a_code_o)
		|-> dac_b_code_o == $past(buffer_code_o)) else $error("no copy");
	b_load_a: assert property (
		update_o && $changed(dac_b_code_o) && $stable(dac_a_code_o)
		|-> dac_b_code_o == buffer_code_o) else $error("b not buffer");
	speed_set_a: assert property (
		$changed(settle_speed_select_o) |-> update_o && !power_down_bit_o)
		else $error("speed changed wrongly");
endmodule : dsl_loader_chk

// *** verification/test_dsl_loader.sv ***
// Self-checking bench for the serial word loader
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
	$display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module test_dsl_loader
	import dsl_pkg::*;
;
	logic ref_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic cs_n, sclk, din, spd_q, pd_q, upd, busy;
	logic [DATA_W-1:0] a_q, b_q, buf_q, ea, eb, ebuf;
	logic [15:0] sr, w;
	logic es, ep;
	int n_fail = 0, n_tests = 0, n_upd = 0, e_upd = 0, cyc = 0;
	integer seed = 32'he8c40bf9;
	logic [15:0] dir_q[$] = '{16'h1ABC, 16'hC123, 16'h4555, 16'h0FFF,
		16'h9000, 16'hB777, 16'h8000, 16'h2000};
	dsl_host_model host_u (.cs_n_o(cs_n), .sclk_o(sclk), .din_o(din));
	dsl_loader dut_u (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
		.cs_n_i(cs_n), .sclk_i(sclk), .din_i(din), .dac_a_code_o(a_q),
		.dac_b_code_o(b_q), .buffer_code_o(buf_q),
		.settle_speed_select_o(spd_q), .power_down_bit_o(pd_q),
		.update_o(upd), .busy_o(busy));
	// Clock
	initial forever #10 ref_clk_i = ~ref_clk_i;
	// Update count and hang guard
	always @(posedge ref_clk_i) begin
		cyc++;
		if (upd === 1'b1)
			n_upd++;
		if (cyc == 20000) begin
			n_fail++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("tests %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : complete_run
	task automatic chk_all();
		`CHK(a_q, ea)
		`CHK(b_q, eb)
		`CHK(buf_q, ebuf)
		`CHK(spd_q, es)
		`CHK(pd_q, ep)
		`CHK(n_upd, e_upd)
		`CHK(busy, 1'b0)
	endtask : chk_all
	// Send n bits, update the model, compare
	task automatic xfer(input logic [15:0] v, input int n, input bit sp);
		logic [1:0] sel;
		bit acc;
		@(posedge ref_clk_i);
		#7 host_u.send(v, n, sp, 1'b0);
		sr = (sr << n) | (v >> (16 - n));
		sel = {sr[15], sr[12]};
		acc = n > 0 && (sr[13] || sel != SEL_RESERVED);
		if (acc && sr[13])
			ep = 1'b1;
		else if (acc) begin
			es = sr[14];
			ep = 1'b0;
			if (sel == SEL_A_AND_COPY) begin
				eb = ebuf;
				ea = sr[11:0];
			end else
				ebuf = sr[11:0];
			if (sel == SEL_B_AND_BUF)
				eb = sr[11:0];
		end
		if (acc)
			e_upd++;
		for (int i = 0; i < 50 && busy !== 1'b0; i++)
			@(posedge ref_clk_i);
		chk_all();
	endtask : xfer
	// Main sequence
	initial begin
		{sr, ea, eb, ebuf, es, ep} = '0;
		repeat (2) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		repeat (4) @(posedge ref_clk_i);
		chk_all();
		$display("test reset done");
		foreach (dir_q[i])
			xfer(dir_q[i], 16, i[0]);
		$display("test directed done");
		#7 host_u.send(16'h4321, 16, 1'b0, 1'b1);
		chk_all();
		xfer(16'h5A5A, 12, 1'b0);
		xfer(16'hFFFF, 0, 1'b0);
		$display("test select high and partial done");
		repeat (24) begin
			w = 16'($random(seed));
			xfer(w, 16, w[0]);
		end
		$display("test random done");
		@(posedge ref_clk_i);
		sys_rst_i <= 1'b1;
		{sr, ea, eb, ebuf, es, ep} = '0;
		repeat (2) @(posedge ref_clk_i);
		chk_all();
		// First word after a mid-run reset release
		sys_rst_i <= 1'b0;
		repeat (4) @(posedge ref_clk_i);
		xfer(16'h4A5A, 16, 1'b0);
		$display("test mid reset done");
		complete_run();
	end
endmodule : test_dsl_loader
bind dsl_loader dsl_loader_chk chk_u (.ref_clk_i, .sys_rst_i, .cs_n_i,
	.sclk_i, .din_i, .dac_a_code_o, .dac_b_code_o, .buffer_code_o,
	.settle_speed_select_o, .power_down_bit_o, .update_o, .busy_o);
